// ==== verilog/sysctl_irq_pkg.sv ====
// Functional notes
// (RL1) Mask bit 6 gates PLL lock interrupt.
// (RL2) Mask bit 5 gates current limit interrupt.
// (RL3) Mask bit 4 gates internal oscillator fault.
// (RL4) Mask bit 3 gates main oscillator fault.
// (RL5) Mask bit 2 gates regulator unregulated interrupt.
// (RL6) Mask bit 1 gates brown-out interrupt.
// (RL7) Mask bit 0 gates PLL fault interrupt.
// (RL8) Masks at 0x054, reset all masked.
// (RL9) Mask bits 31:7 reserved, read zero.
// (RL10) Raw status set by hardware, read-only.
// (RL11) Masked status at 0x058, write-one clears.
// (RL12) Brown-out interrupt needs select bit clear.
// (RL13) One request: OR of masked events.
package sysctl_irq_pkg;
	localparam int          ADDR_W            = 12;
	localparam int          DATA_W            = 32;
	localparam int          EVT_N             = 7;
	localparam logic [11:0] RAW_STATUS_OFS    = 12'h050;
	localparam logic [11:0] EVENT_MASK_OFS    = 12'h054;
	localparam logic [11:0] MASKED_STATUS_OFS = 12'h058;
	localparam int          PLL_LOCK_BIT      = 6;
	localparam int          CURRENT_LIMIT_BIT = 5;
	localparam int          INT_OSC_BIT       = 4;
	localparam int          MAIN_OSC_BIT      = 3;
	localparam int          REGULATOR_BIT     = 2;
	localparam int          BROWNOUT_BIT      = 1;
	localparam int          PLL_FAULT_BIT     = 0;
	localparam logic [6:0]  EVENT_MASK_RESET  = 7'h00;
	localparam logic [6:0]  RAW_RESET         = 7'h00;
	localparam logic [24:0] RESERVED_READ     = 25'h0000000;
endpackage

// ==== verilog/event_if.sv ====
`timescale 1ns/1ns
interface event_if;
	logic [6:0] rise;
	logic [6:0] clear;
	logic [6:0] raw;
	modport src  (output rise);
	modport stat (input rise, input clear, output raw);
	modport ctl  (input raw, output clear);
endinterface

// ==== verilog/event_sync.sv ====
`timescale 1ns/1ns
module event_sync (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       reset_in,
	// Asynchronous event levels
	input  wire logic [6:0] event_in,
	// Synchronised rising edges
	event_if.src            evt
);
	genvar i;
	generate
		for (i = 0; i < sysctl_irq_pkg::EVT_N; i++) begin : g_bit
			logic s1_reg;
			logic s2_reg;
			logic s3_reg;
			logic level_reg;
			always_ff @(posedge clk_in) begin
				if (reset_in) begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
					s3_reg <= 1'b0;
				end else begin
					s1_reg <= event_in[i];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
				end
			end
			// A change counts only once the second and third stages agree.
			always_ff @(posedge clk_in) begin
				if (reset_in) begin
					level_reg <= 1'b0;
				end else if (s2_reg == s3_reg) begin
					level_reg <= s3_reg;
				end
			end
			assign evt.rise[i] = (s2_reg == s3_reg) && s3_reg && !level_reg;
		end
	endgenerate
endmodule

// ==== verilog/raw_status.sv ====
`timescale 1ns/1ns
module raw_status (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic reset_in,
	// Event edges, clears and sticky raw bits
	event_if.stat     evt
);
	logic [6:0] raw_reg;
	logic [6:0] raw_next;
	// Hardware sets these and a write-one to masked status clears them; a set in the clearing cycle wins.
	always_comb begin
		raw_next = (raw_reg & ~evt.clear) | evt.rise; // RL10
	end
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			raw_reg <= sysctl_irq_pkg::RAW_RESET;
		end else begin
			raw_reg <= raw_next;
		end
	end
	assign evt.raw = raw_reg;
endmodule

// ==== verilog/sysctl_interrupt_mask.sv ====
`timescale 1ns/1ns
module sysctl_interrupt_mask (
	// Clock and reset
	input  wire logic        SYS_CLK_IN,
	input  wire logic        RESET_IN,
	// Register port
	input  wire logic [11:0] ADDR_IN,
	input  wire logic [31:0] WR_DATA_IN,
	input  wire logic        WR_IN,
	input  wire logic        RD_IN,
	output logic      [31:0] RD_DATA_OUT,
	// Hardware event levels from the clock, power and PLL monitors
	input  wire logic        PLL_LOCK_IN,
	input  wire logic        CURRENT_LIMIT_IN,
	input  wire logic        INT_OSC_FAULT_IN,
	input  wire logic        MAIN_OSC_FAULT_IN,
	input  wire logic        REGULATOR_FAULT_IN,
	input  wire logic        BROWNOUT_IN,
	input  wire logic        PLL_FAULT_IN,
	// Brown-out interrupt-or-reset select from the brown-out control logic
	input  wire logic        BROWNOUT_IRQ_OR_RESET_SEL_IN,
	// Interrupt request to the processor
	output logic             IRQ_OUT
);
	event_if evt ();

	logic [6:0]  event_level;
	logic [6:0]  event_mask_reg;
	logic [6:0]  event_mask_next;
	logic [6:0]  masked;
	logic [6:0]  clear_mask;
	logic [31:0] rd_data_reg;
	logic [31:0] rd_data_next;
	logic        irq_reg;
	logic        brownout_enable;
	logic        wr_mask;
	logic        wr_clear;

	assign event_level[sysctl_irq_pkg::PLL_LOCK_BIT]      = PLL_LOCK_IN;
	assign event_level[sysctl_irq_pkg::CURRENT_LIMIT_BIT] = CURRENT_LIMIT_IN;
	assign event_level[sysctl_irq_pkg::INT_OSC_BIT]       = INT_OSC_FAULT_IN;
	assign event_level[sysctl_irq_pkg::MAIN_OSC_BIT]      = MAIN_OSC_FAULT_IN;
	assign event_level[sysctl_irq_pkg::REGULATOR_BIT]     = REGULATOR_FAULT_IN;
	assign event_level[sysctl_irq_pkg::BROWNOUT_BIT]      = BROWNOUT_IN;
	assign event_level[sysctl_irq_pkg::PLL_FAULT_BIT]     = PLL_FAULT_IN;

	event_sync u_sync (
		.clk_in   (SYS_CLK_IN),
		.reset_in (RESET_IN),
		.event_in (event_level),
		.evt      (evt)
	);

	raw_status u_raw (
		.clk_in   (SYS_CLK_IN),
		.reset_in (RESET_IN),
		.evt      (evt)
	);

	assign wr_mask  = WR_IN && (ADDR_IN == sysctl_irq_pkg::EVENT_MASK_OFS);
	assign wr_clear = WR_IN && (ADDR_IN == sysctl_irq_pkg::MASKED_STATUS_OFS);

	// Reserved bits 31:7 of a write are dropped.
	always_comb begin
		event_mask_next = event_mask_reg;
		if (wr_mask) begin
			event_mask_next = WR_DATA_IN[6:0]; // RL8 RL9
		end
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (RESET_IN) begin
			event_mask_reg <= sysctl_irq_pkg::EVENT_MASK_RESET; // RL8
		end else begin
			event_mask_reg <= event_mask_next;
		end
	end

	// Writing one to a masked status bit also clears the matching raw bit.
	always_comb begin
		clear_mask = 7'h00;
		if (wr_clear) begin
			clear_mask = WR_DATA_IN[6:0]; // RL11
		end
	end
	assign evt.clear = clear_mask;

	assign brownout_enable = !BROWNOUT_IRQ_OR_RESET_SEL_IN; // RL12

	always_comb begin
		masked = 7'h00;
		masked[sysctl_irq_pkg::PLL_LOCK_BIT] = evt.raw[sysctl_irq_pkg::PLL_LOCK_BIT]
			&& event_mask_reg[sysctl_irq_pkg::PLL_LOCK_BIT]; // RL1
		masked[sysctl_irq_pkg::CURRENT_LIMIT_BIT] = evt.raw[sysctl_irq_pkg::CURRENT_LIMIT_BIT]
			&& event_mask_reg[sysctl_irq_pkg::CURRENT_LIMIT_BIT]; // RL2
		masked[sysctl_irq_pkg::INT_OSC_BIT] = evt.raw[sysctl_irq_pkg::INT_OSC_BIT]
			&& event_mask_reg[sysctl_irq_pkg::INT_OSC_BIT]; // RL3
		masked[sysctl_irq_pkg::MAIN_OSC_BIT] = evt.raw[sysctl_irq_pkg::MAIN_OSC_BIT]
			&& event_mask_reg[sysctl_irq_pkg::MAIN_OSC_BIT]; // RL4
		masked[sysctl_irq_pkg::REGULATOR_BIT] = evt.raw[sysctl_irq_pkg::REGULATOR_BIT]
			&& event_mask_reg[sysctl_irq_pkg::REGULATOR_BIT]; // RL5
		masked[sysctl_irq_pkg::BROWNOUT_BIT] = evt.raw[sysctl_irq_pkg::BROWNOUT_BIT]
			&& event_mask_reg[sysctl_irq_pkg::BROWNOUT_BIT] && brownout_enable; // RL6 RL12
		masked[sysctl_irq_pkg::PLL_FAULT_BIT] = evt.raw[sysctl_irq_pkg::PLL_FAULT_BIT]
			&& event_mask_reg[sysctl_irq_pkg::PLL_FAULT_BIT]; // RL7
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (RESET_IN) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |masked; // RL13
		end
	end

	// Unmapped addresses and reserved bits read as zero.
	always_comb begin
		rd_data_next = 32'h00000000;
		if (RD_IN) begin
			unique case (ADDR_IN)
				sysctl_irq_pkg::RAW_STATUS_OFS: begin
					rd_data_next = {sysctl_irq_pkg::RESERVED_READ, evt.raw}; // RL10
				end
				sysctl_irq_pkg::EVENT_MASK_OFS: begin
					rd_data_next = {sysctl_irq_pkg::RESERVED_READ, event_mask_reg}; // RL9
				end
				sysctl_irq_pkg::MASKED_STATUS_OFS: begin
					rd_data_next = {sysctl_irq_pkg::RESERVED_READ, masked}; // RL11
				end
				default: begin
					rd_data_next = 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (RESET_IN) begin
			rd_data_reg <= 32'h00000000;
		end else begin
			rd_data_reg <= rd_data_next;
		end
	end

	assign RD_DATA_OUT = rd_data_reg;
	assign IRQ_OUT     = irq_reg;
endmodule

// ==== test/irq_taker.sv ====
`timescale 1ns/1ns
module irq_taker (
	input  wire logic       clk_in,
	input  wire logic       irq_in,
	output logic      [7:0] taken_out
);
	logic irq_d = 1'h0;
	initial taken_out = 8'h00;
	// Counts each new request, as the processor would enter its handler once per rise.
	always @(posedge clk_in) begin
		irq_d <= irq_in;
		if (irq_in && !irq_d) taken_out <= taken_out + 8'h01;
	end
endmodule

// ==== test/sysctl_interrupt_mask_properties.sv ====
`timescale 1ns/1ns
module sysctl_interrupt_mask_chk (
	input wire logic        SYS_CLK_IN, RESET_IN, WR_IN, RD_IN, IRQ_OUT,
	input wire logic [11:0] ADDR_IN,
	input wire logic [31:0] WR_DATA_IN, RD_DATA_OUT,
	input wire logic        PLL_LOCK_IN, CURRENT_LIMIT_IN, INT_OSC_FAULT_IN, MAIN_OSC_FAULT_IN,
	input wire logic        REGULATOR_FAULT_IN, BROWNOUT_IN, PLL_FAULT_IN, BROWNOUT_IRQ_OR_RESET_SEL_IN
);
	logic [6:0] mask_reg, ev_reg, ev_now, bor_off;
	assign ev_now = {PLL_LOCK_IN, CURRENT_LIMIT_IN, INT_OSC_FAULT_IN, MAIN_OSC_FAULT_IN,
		REGULATOR_FAULT_IN, BROWNOUT_IN, PLL_FAULT_IN};
	assign bor_off = {5'h00, BROWNOUT_IRQ_OR_RESET_SEL_IN, 1'h0};
	always_ff @(posedge SYS_CLK_IN) ev_reg <= RESET_IN ? 7'h00 : ev_now;
	always_ff @(posedge SYS_CLK_IN) begin
		if (RESET_IN) mask_reg <= 7'h00;
		else if (WR_IN && ADDR_IN == 12'h054) mask_reg <= WR_DATA_IN[6:0];
	end
	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (RESET_IN);
	a_reset_quiet: assert property ($past(RESET_IN) |-> !IRQ_OUT && RD_DATA_OUT == 32'h0)
		else $error("not clear after reset");
	a_mask_readback: assert property (RD_IN && ADDR_IN == 12'h054 |=> RD_DATA_OUT == {25'h0, $past(mask_reg)})
		else $error("mask readback");
	a_resv_zero: assert property ($past(RD_IN) |-> RD_DATA_OUT[31:7] == 25'h0)
		else $error("reserved bits");
	a_status_and: assert property (RD_IN && ADDR_IN == 12'h058 |=> (RD_DATA_OUT[6:0] & ~$past(mask_reg)) == 7'h00)
		else $error("masked status");
	a_bor_sel: assert property (RD_IN && ADDR_IN == 12'h058 && bor_off[1] |=> !RD_DATA_OUT[1])
		else $error("brown-out select");
	a_masked_quiet: assert property ($past(mask_reg) == 7'h00 |-> !IRQ_OUT)
		else $error("request while masked");
	a_irq_event: assert property (|(ev_now & ~ev_reg & mask_reg & ~bor_off) |-> ##[1:6] IRQ_OUT)
		else $error("no request");
	a_unmapped_zero: assert property (RD_IN && !(ADDR_IN inside {12'h050, 12'h054, 12'h058}) |=> RD_DATA_OUT == 32'h0)
		else $error("unmapped read");
	c_irq: cover property ($rose(IRQ_OUT));
	c_clear: cover property (WR_IN && ADDR_IN == 12'h058);
	c_sel: cover property (bor_off[1] && BROWNOUT_IN);
endmodule
bind sysctl_interrupt_mask sysctl_interrupt_mask_chk sysctl_interrupt_mask_chk_inst (.*);

// ==== test/sysctl_interrupt_mask_tb_top.sv ====
`timescale 1ns/1ns
module sysctl_interrupt_mask_tb_top;
	logic clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, sel = 1'h0, rd_d = 1'h0, irq;
	logic [11:0] addr = 12'h000;
	logic [31:0] wd = 32'h0, seed = 32'h9FF1, rdat, exp_q[$];
	logic [6:0] ev = 7'h00;
	logic [7:0] taken;
	int err_total = 0, n_tests = 0, cyc = 0;
	sysctl_interrupt_mask sysctl_interrupt_mask_inst (.SYS_CLK_IN(clk), .RESET_IN(rst), .ADDR_IN(addr),
		.WR_DATA_IN(wd), .WR_IN(wr), .RD_IN(rd), .RD_DATA_OUT(rdat), .PLL_LOCK_IN(ev[6]), .CURRENT_LIMIT_IN(ev[5]),
		.INT_OSC_FAULT_IN(ev[4]), .MAIN_OSC_FAULT_IN(ev[3]), .REGULATOR_FAULT_IN(ev[2]), .BROWNOUT_IN(ev[1]),
		.PLL_FAULT_IN(ev[0]), .BROWNOUT_IRQ_OR_RESET_SEL_IN(sel), .IRQ_OUT(irq));
	irq_taker irq_taker_inst (.clk_in(clk), .irq_in(irq), .taken_out(taken));
	initial forever #2 clk = ~clk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk) {addr, wd, wr} <= {a, d, 1'h1};
		@(posedge clk) wr <= 1'h0;
	endtask
	task automatic rd_reg(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk) {addr, rd} <= {a, 1'h1};
		exp_q.push_back(e);
		@(posedge clk) rd <= 1'h0;
	endtask
	task automatic final_report;
		$display("compares %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk) rd_d <= rd;
	always @(negedge clk) if (rd_d) chk(rdat, exp_q.pop_front());
	always @(posedge clk) if (++cyc > 2000) begin
		err_total++;
		final_report;
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		rd_reg(12'h054, 32'h0);
		rd_reg(12'h058, 32'h0);
		for (int i = 0; i < 6; i++) begin
			seed = xs(seed);
			wr_reg(12'h054, {25'h0, seed[6:0]});
			rd_reg(12'h054, {25'h0, seed[6:0]});
		end
		wr_reg(12'h0FC, 32'h7F);
		rd_reg(12'h0FC, 32'h0);
		rd_reg(12'h054, {25'h0, seed[6:0]});
		$display("mask test done");
		for (int k = 0; k < 7; k++) begin
			wr_reg(12'h054, 32'h1 << k);
			ev <= 7'h01 << k;
			repeat (8) @(posedge clk);
			ev <= 7'h00;
			@(negedge clk) chk({31'h0, irq}, 32'h1);
			wr_reg(12'h050, 32'h0);
			rd_reg(12'h050, 32'h1 << k);
			rd_reg(12'h058, 32'h1 << k);
			wr_reg(12'h054, 32'h0);
			rd_reg(12'h058, 32'h0);
			@(negedge clk) chk({31'h0, irq}, 32'h0);
			wr_reg(12'h058, 32'h1 << k);
			rd_reg(12'h050, 32'h0);
		end
		$display("event test done");
		sel <= 1'h1;
		wr_reg(12'h054, 32'h2);
		ev <= 7'h02;
		repeat (8) @(posedge clk);
		rd_reg(12'h058, 32'h0);
		rd_reg(12'h050, 32'h2);
		@(negedge clk) chk({31'h0, irq}, 32'h0);
		chk({24'h0, taken}, 32'h7);
		$display("select test done");
		wr_reg(12'h054, 32'h7F);
		rst <= 1'h1;
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		rd_reg(12'h054, 32'h0);
		$display("reset test done");
		repeat (2) @(posedge clk);
		final_report;
	end
endmodule
